// ==== hdl/pai_top.sv ====
// Process alarm indicator core: filtering, limit alarms, contacts, lamps, restart, APB registers
//
// How it works
// RULE_01: Four setpoints and hysteresis per process value
// RULE_02: Six contacts; sixth may be backlight input
// RULE_03: Contacts combine chosen alarms by AND/OR
// RULE_04: Contact active polarity selectable closed or open
// RULE_05: All contacts open while power lost
// RULE_06: Alarm lights yellow lamp, shows cause
// RULE_07: First-order lag filter, tunable time constant
// RULE_08: Optional square root with low cutoff
// RULE_09: Output clamped between high and low limits
// RULE_10: All computation repeats every 100 ms
// RULE_11: Restart hot or cold by mode, outage
// RULE_12: Parameters survive power failure unchanged
// RULE_13: Hot start keeps filter; cold reinitialises
// RULE_14: Seven self-diagnosis faults declare failure
// RULE_15: Failure lights red lamp, opens contact
// RULE_16: Active display recolours bar on alarm
// RULE_17: Tag highlight alternates while lamp lit
// RULE_18: Surviving processor shows the failure display
// RULE_19: Alarm clears only past setpoint plus hysteresis
`timescale 1ns/1ps
`include "pai_cfg.svh"

module pai_top import pai_pkg::*; #(
  parameter int PERIOD_CYC = `PAI_PERIOD_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [15:0] process_value0_i,
  input wire logic [15:0] process_value1_i,
  input wire logic power_ok_i,
  input wire logic [6:0] fault_i,
  input wire logic sys_alarm_i,
  input wire logic contact_input_point_i,
  output logic [5:0] contact_closed_o,
  output logic contact6_oe_o,
  output logic backlight_off_o,
  output logic [15:0] manipulated_output_o,
  output logic alarm_lamp_o,
  output logic [8:0] alarm_cause_o,
  output logic [1:0] pv_bar_alert_o,
  output logic tag_invert_o,
  output logic fail_lamp_o,
  output logic fail_contact_closed_o,
  output logic fail_display_main_o,
  output logic fail_display_disp_o,
  output logic irq_o
);

  // ----------------------------------------
  // Pin synchronisers (a process word is taken once two samples agree)
  // ----------------------------------------
  logic [15:0] pv_s1_ff [2];
  logic [15:0] pv_s2_ff [2];
  logic [15:0] pv_s3_ff [2], pv_word_ff [2];
  logic [9:0] pin_s1_ff;
  logic [9:0] pin_s2_ff;
  wire logic power_ok = pin_s2_ff[0];
  wire logic sys_alarm = pin_s2_ff[1];
  wire logic c6_in = pin_s2_ff[2];
  wire logic [6:0] fault = pin_s2_ff[9:3];

  always_ff @(posedge mclk_i) begin
    pv_s1_ff[0] <= process_value0_i;
    pv_s1_ff[1] <= process_value1_i;
    pv_s2_ff <= pv_s1_ff;
    pv_s3_ff <= pv_s2_ff;
    if (pv_s2_ff[0] == pv_s3_ff[0]) pv_word_ff[0] <= pv_s2_ff[0];
    if (pv_s2_ff[1] == pv_s3_ff[1]) pv_word_ff[1] <= pv_s2_ff[1];
    pin_s1_ff <= {fault_i, contact_input_point_i, sys_alarm_i, power_ok_i};
    pin_s2_ff <= pin_s1_ff;
  end

  // ----------------------------------------
  // Registers (flops only reset by reset_i, never by power loss)
  // ----------------------------------------
  logic [`PAI_CTRL_W-1:0] ctrl_ff;
  pai_val_t chp_ff [2][`PAI_CH_FIELDS];
  pai_val_t out_hi_ff;
  pai_val_t out_lo_ff;
  logic [`PAI_CON_W-1:0] con_ff [6];
  logic [9:0] irq_stat_ff;
  logic [9:0] irq_mask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  wire logic setup = psel_i & ~penable_i;
  wire logic wr_en = psel_i & penable_i & pready_ff & pwrite_i & ~pslverr_ff;
  wire logic rd_done = psel_i & penable_i & pready_ff & ~pwrite_i;
  wire logic [11:0] a = {paddr_i[11:2], 2'b00};
  wire logic ch_hit = (a[11:5] == `PAI_OFS_CH0 >> 5 || a[11:5] == `PAI_OFS_CH1 >> 5)
                      && a[4:2] < 3'(`PAI_CH_FIELDS);
  wire logic ch_sel = (a[11:5] == `PAI_OFS_CH1 >> 5);
  wire logic [2:0] fld = a[4:2];
  wire logic con_hit = a >= `PAI_OFS_CONTACT && a < `PAI_OFS_CONTACT + 12'h0018;
  wire logic [2:0] con_idx = 3'((a - `PAI_OFS_CONTACT) >> 2);
  wire logic hit_ctrl = a == `PAI_OFS_CTRL;
  wire logic hit_ohi = a == `PAI_OFS_OUT_HI;
  wire logic hit_olo = a == `PAI_OFS_OUT_LO;
  wire logic hit_stat = a == `PAI_OFS_STATUS;
  wire logic hit_istat = a == `PAI_OFS_IRQ_STAT;
  wire logic hit_imask = a == `PAI_OFS_IRQ_MASK;
  wire logic mapped = ch_hit | con_hit | hit_ctrl | hit_ohi | hit_olo | hit_stat
                      | hit_istat | hit_imask;

  // Process state read back
  logic [7:0] alarm_ff;
  logic fail_ff;
  logic restart_hot_ff;
  logic [31:0] status_word;
  assign status_word = {20'h0_0000, backlight_off_o, restart_hot_ff, sys_alarm, fail_ff,
                        alarm_ff};

  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (ch_hit) begin
      rd_word = {{16{chp_ff[ch_sel][fld][15]}}, chp_ff[ch_sel][fld]};
    end else if (con_hit) begin
      rd_word = {22'h00_0000, con_ff[con_idx]};
    end else if (hit_ctrl) begin
      rd_word = {24'h00_0000, ctrl_ff};
    end else if (hit_ohi) begin
      rd_word = {{16{out_hi_ff[15]}}, out_hi_ff};
    end else if (hit_olo) begin
      rd_word = {{16{out_lo_ff[15]}}, out_lo_ff};
    end else if (hit_stat) begin
      rd_word = status_word;
    end else if (hit_istat) begin
      rd_word = {22'h00_0000, irq_stat_ff};
    end else if (hit_imask) begin
      rd_word = {22'h00_0000, irq_mask_ff};
    end
  end

  // Data is captured in setup so the access phase completes in one cycle
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~mapped;
      prdata_ff <= setup ? rd_word : prdata_ff;
    end
  end

  // RULE_12 Parameters persist
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_ff <= '0;
      out_hi_ff <= `PAI_RST_HH;
      out_lo_ff <= `PAI_RST_LL;
      irq_mask_ff <= '0;
      for (int c = 0; c < 2; c++) begin
        chp_ff[c][`PAI_F_HI] <= `PAI_RST_HI;
        chp_ff[c][`PAI_F_LO] <= `PAI_RST_LO;
        chp_ff[c][`PAI_F_HH] <= `PAI_RST_HH;
        chp_ff[c][`PAI_F_LL] <= `PAI_RST_LL;
        chp_ff[c][`PAI_F_HYST] <= `PAI_RST_HYST;
        chp_ff[c][`PAI_F_TAU] <= `PAI_RST_TAU;
        chp_ff[c][`PAI_F_CUT] <= `PAI_RST_CUT;
      end
      for (int k = 0; k < 6; k++) begin
        con_ff[k] <= '0;
      end
    end else if (wr_en) begin
      // RULE_01 Setpoint storage
      if (ch_hit) chp_ff[ch_sel][fld] <= pwdata_i[15:0];
      if (con_hit) con_ff[con_idx] <= pwdata_i[`PAI_CON_W-1:0];
      if (hit_ctrl) ctrl_ff <= pwdata_i[`PAI_CTRL_W-1:0];
      if (hit_ohi) out_hi_ff <= pwdata_i[15:0];
      if (hit_olo) out_lo_ff <= pwdata_i[15:0];
      if (hit_imask) irq_mask_ff <= pwdata_i[9:0];
    end
  end

  // ----------------------------------------
  // Period tick and power sequencing
  // ----------------------------------------
  logic [24:0] tick_cnt_ff;
  wire logic tick = tick_cnt_ff == 25'(PERIOD_CYC - 1);
  pai_state_e state_ff;
  logic [7:0] outage_ff;
  logic init_ff;

  // RULE_10 100 ms period
  always_ff @(posedge mclk_i) begin
    if (reset_i) tick_cnt_ff <= '0;
    else tick_cnt_ff <= tick ? 25'h000_0000 : tick_cnt_ff + 25'h000_0001;
  end

  wire logic cold_mode = ctrl_ff[`PAI_CTRL_COLD];
  wire logic long_outage = outage_ff >= 8'(`PAI_OUTAGE_TICKS);
  wire logic running = state_ff == PAI_RUN;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_ff <= PAI_RUN;
      outage_ff <= '0;
      init_ff <= 1'b1;
      restart_hot_ff <= 1'b0;
    end else begin
      case (state_ff)
        PAI_RUN: begin
          if (!power_ok) begin
            state_ff <= PAI_DOWN;
            outage_ff <= '0;
          end else if (tick) begin
            init_ff <= 1'b0;
          end
        end
        PAI_DOWN: begin
          if (tick && !long_outage) outage_ff <= outage_ff + 8'h01;
          if (power_ok) begin
            state_ff <= PAI_RUN;
            // RULE_11 Hot or cold choice
            restart_hot_ff <= !cold_mode || !long_outage;
            // RULE_13 Cold start reinitialises filter
            if (cold_mode && long_outage) init_ff <= 1'b1;
          end
        end
        default: state_ff <= PAI_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // Per-channel computation
  // ----------------------------------------
  function automatic logic [11:0] isqrt(input logic [23:0] x);
    logic [23:0] rem;
    logic [11:0] root;
    logic [11:0] trial;
    rem = x;
    root = '0;
    for (int b = 11; b >= 0; b--) begin
      trial = root | (12'h001 << b);
      if ({12'h000, trial} * {12'h000, trial} <= rem) root = trial;
    end
    return root;
  endfunction : isqrt

  logic [7:0] nxt_alarm;
  pai_val_t proc_val [2];

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic signed [31:0] filt_ff;
    wire logic signed [31:0] x_fx = {pv_word_ff[c], 16'h0000};
    wire logic signed [31:0] tau_p1 = {16'h0000, chp_ff[c][`PAI_F_TAU]} + 32'sh0000_0001;
    // RULE_07 Lag filter, one 0.1 s step per tick
    wire logic signed [31:0] step = (x_fx - filt_ff) / tau_p1;
    wire pai_val_t lagged = filt_ff[31:16];
    wire pai_val_t cut = chp_ff[c][`PAI_F_CUT];
    wire logic [11:0] root = isqrt({8'h00, lagged} * `PAI_SQRT_SCALE);
    wire pai_val_t hyst = chp_ff[c][`PAI_F_HYST];
    wire pai_val_t sp_hi = chp_ff[c][`PAI_F_HI];
    wire pai_val_t sp_lo = chp_ff[c][`PAI_F_LO];
    wire pai_val_t sp_hh = chp_ff[c][`PAI_F_HH];
    wire pai_val_t sp_ll = chp_ff[c][`PAI_F_LL];
    wire pai_val_t v = proc_val[c];
    wire logic [3:0] cur = alarm_ff[4*c +: 4];

    // RULE_08 Square root below cutoff gives zero
    assign proc_val[c] = !ctrl_ff[`PAI_CTRL_SQRT + c] ? lagged :
                         (lagged <= 0 || lagged < cut) ? 16'sh0000 : {4'h0, root};

    // RULE_19 Hysteresis on clearing
    assign nxt_alarm[4*c+0] = cur[0] ? (v >= sp_hi - hyst) : (v >= sp_hi);
    assign nxt_alarm[4*c+1] = cur[1] ? (v <= sp_lo + hyst) : (v <= sp_lo);
    assign nxt_alarm[4*c+2] = cur[2] ? (v >= sp_hh - hyst) : (v >= sp_hh);
    assign nxt_alarm[4*c+3] = cur[3] ? (v <= sp_ll + hyst) : (v <= sp_ll);

    always_ff @(posedge mclk_i) begin
      if (reset_i) filt_ff <= '0;
      // RULE_13 Filter resumes unless initialised
      else if (tick && running) filt_ff <= init_ff ? x_fx : filt_ff + step;
    end
  end

  // Alarms evaluate one cycle after the filter tick so they see the settled value
  logic tick_d_ff;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tick_d_ff <= 1'b0;
      alarm_ff <= '0;
      manipulated_output_o <= '0;
    end else begin
      tick_d_ff <= tick & running;
      if (running && init_ff && tick) alarm_ff <= '0;
      else if (tick_d_ff) alarm_ff <= nxt_alarm;
      // RULE_09 Output limiter
      if (tick_d_ff) begin
        manipulated_output_o <= (proc_val[0] > out_hi_ff) ? out_hi_ff :
                                (proc_val[0] < out_lo_ff) ? out_lo_ff : proc_val[0];
      end
    end
  end

  // ----------------------------------------
  // Contacts
  // ----------------------------------------
  logic [5:0] nxt_contact;
  wire logic c6_input = ctrl_ff[`PAI_CTRL_C6IN];
  for (genvar k = 0; k < 6; k++) begin : g_con
    wire logic [7:0] sel = con_ff[k][7:0];
    // RULE_03 AND or OR of chosen alarms
    wire logic act = con_ff[k][`PAI_CON_OR] ? |(alarm_ff & sel) :
                     (sel != 8'h00) && &(alarm_ff | ~sel);
    // RULE_04 Polarity, RULE_05 open on power loss
    assign nxt_contact[k] = power_ok && (act ^ con_ff[k][`PAI_CON_OPEN]) &&
                            !(k == 5 && c6_input);
  end

  // ----------------------------------------
  // Lamps, display cues, diagnosis
  // ----------------------------------------
  wire logic lamp = (|alarm_ff) | sys_alarm;
  wire logic [1:0] asel = ctrl_ff[`PAI_CTRL_ASEL +: 2];
  wire logic [6:0] nxt_fault = fault;
  wire logic main_bad = fault[1];
  wire logic disp_bad = fault[2];

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      contact_closed_o <= '0;
      contact6_oe_o <= 1'b0;
      backlight_off_o <= 1'b0;
      alarm_lamp_o <= 1'b0;
      alarm_cause_o <= '0;
      pv_bar_alert_o <= '0;
      tag_invert_o <= 1'b0;
      fail_ff <= 1'b0;
      fail_lamp_o <= 1'b0;
      fail_contact_closed_o <= 1'b0;
      fail_display_main_o <= 1'b0;
      fail_display_disp_o <= 1'b0;
    end else begin
      contact_closed_o <= nxt_contact;
      // RULE_02 Sixth contact as input point
      contact6_oe_o <= !c6_input;
      backlight_off_o <= c6_input & c6_in;
      // RULE_06 Yellow lamp and cause
      alarm_lamp_o <= lamp;
      alarm_cause_o <= {sys_alarm, alarm_ff};
      // RULE_16 Active display bar colour
      pv_bar_alert_o[0] <= ctrl_ff[`PAI_CTRL_ACT] & alarm_ff[asel];
      pv_bar_alert_o[1] <= ctrl_ff[`PAI_CTRL_ACT] & alarm_ff[4 + asel];
      // RULE_17 Tag alternates each period
      if (!(lamp && ctrl_ff[`PAI_CTRL_TAG])) tag_invert_o <= 1'b0;
      else if (tick) tag_invert_o <= !tag_invert_o;
      // RULE_14 Any diagnosed fault
      fail_ff <= |nxt_fault;
      // RULE_15 Red lamp, failure contact opens
      fail_lamp_o <= |nxt_fault;
      fail_contact_closed_o <= power_ok & ~(|nxt_fault);
      // RULE_18 Surviving processor shows failure
      fail_display_main_o <= (|nxt_fault) & ~fault[0] & ~main_bad;
      fail_display_disp_o <= main_bad & ~disp_bad & ~fault[0];
    end
  end

  // ----------------------------------------
  // Interrupts: sticky, a read clears only the bits it returned, set wins
  // ----------------------------------------
  logic [9:0] ev_prev_ff;
  wire logic [9:0] ev_now = {sys_alarm, fail_ff, alarm_ff};
  wire logic [9:0] ev_rise = ev_now & ~ev_prev_ff;
  wire logic istat_clr = rd_done & hit_istat;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ev_prev_ff <= '0;
      irq_stat_ff <= '0;
      irq_o <= 1'b0;
    end else begin
      ev_prev_ff <= ev_now;
      irq_stat_ff <= (irq_stat_ff & ~(istat_clr ? prdata_ff[9:0] : 10'h000)) | ev_rise;
      irq_o <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;

endmodule : pai_top

// ==== inc/pai_cfg.svh ====
// Constants of the process alarm indicator: offsets, fields, reset values and timing
`ifndef PAI_CFG_SVH
`define PAI_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PAI_CLK_KHZ 200000
`define PAI_PERIOD_MS 100
`define PAI_OUTAGE_MS 2000
`define PAI_PERIOD_CYC (`PAI_PERIOD_MS * `PAI_CLK_KHZ)
`define PAI_OUTAGE_TICKS (`PAI_OUTAGE_MS / `PAI_PERIOD_MS)

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PAI_OFS_CTRL 12'h0000
`define PAI_OFS_CH0 12'h0020
`define PAI_OFS_CH1 12'h0040
`define PAI_OFS_OUT_HI 12'h0060
`define PAI_OFS_OUT_LO 12'h0064
`define PAI_OFS_CONTACT 12'h0070
`define PAI_OFS_STATUS 12'h0090
`define PAI_OFS_IRQ_STAT 12'h0094
`define PAI_OFS_IRQ_MASK 12'h0098

// ----------------------------------------
// Fields
// ----------------------------------------
`define PAI_CH_FIELDS 7
`define PAI_F_HI 0
`define PAI_F_LO 1
`define PAI_F_HH 2
`define PAI_F_LL 3
`define PAI_F_HYST 4
`define PAI_F_TAU 5
`define PAI_F_CUT 6
`define PAI_CTRL_COLD 0
`define PAI_CTRL_TAG 1
`define PAI_CTRL_ACT 2
`define PAI_CTRL_C6IN 3
`define PAI_CTRL_ASEL 4
`define PAI_CTRL_SQRT 6
`define PAI_CTRL_W 8
`define PAI_CON_OR 8
`define PAI_CON_OPEN 9
`define PAI_CON_W 10
`define PAI_SQRT_SCALE 24'h00_03e8

// ----------------------------------------
// Reset values (0.1 percent or 0.1 s units)
// ----------------------------------------
`define PAI_RST_HI 16'h03e8
`define PAI_RST_LO 16'h0000
`define PAI_RST_HH 16'h0427
`define PAI_RST_LL 16'hffc1
`define PAI_RST_HYST 16'h000a
`define PAI_RST_TAU 16'h0000
`define PAI_RST_CUT 16'h0000

`endif

// ==== inc/pai_pkg.sv ====
// Types shared by the process alarm indicator
package pai_pkg;
  typedef enum logic {PAI_RUN, PAI_DOWN} pai_state_e;
  typedef logic signed [15:0] pai_val_t;
endpackage : pai_pkg

// ==== dv/pai_field.sv ====
// Field side model: transmitters, supply, fault sources and backlight switch
`timescale 1ns/1ps
module pai_field (
  input wire logic [15:0] lvl0_i,
  input wire logic [15:0] lvl1_i,
  input wire logic mains_i,
  input wire logic [6:0] flt_i,
  input wire logic sys_i,
  input wire logic switch_i,
  input wire logic contact6_oe_i,
  output logic [15:0] process_value0_o,
  output logic [15:0] process_value1_o,
  output logic power_ok_o,
  output logic [6:0] fault_o,
  output logic sys_alarm_o,
  output logic contact_input_point_o
);
  assign process_value0_o = lvl0_i;
  assign process_value1_o = lvl1_i;
  assign power_ok_o = mains_i;
  assign fault_o = flt_i;
  assign sys_alarm_o = sys_i;
  // Switch shares the sixth terminal: seen only once the device lets go
  assign contact_input_point_o = switch_i && !contact6_oe_i;
endmodule : pai_field

// ==== dv/pai_monitor.sv ====
// Checker of the indicator outputs
`timescale 1ns/1ps
module pai_monitor (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic power_ok_i,
  input wire logic [6:0] fault_i,
  input wire logic [5:0] contact_closed_o,
  input wire logic contact6_oe_o,
  input wire logic backlight_off_o,
  input wire logic [15:0] manipulated_output_o,
  input wire logic alarm_lamp_o,
  input wire logic [8:0] alarm_cause_o,
  input wire logic tag_invert_o,
  input wire logic fail_lamp_o,
  input wire logic fail_contact_closed_o,
  input wire logic fail_display_main_o,
  input wire logic fail_display_disp_o
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_loss_contacts_open: assert property (
    !power_ok_i [*5] |-> contact_closed_o == 6'h0 && !fail_contact_closed_o)
    else $error("contact closed without power");
  // Fault inputs pass two synchroniser stages and one register, so the lamp follows 3 cycles later, inside the range
  a_fault_lights_lamp: assert property (
    $rose(|fault_i) && power_ok_i |-> ##[1:120] fail_lamp_o)
    else $error("fault without fail lamp");
  a_fail_opens_contact: assert property (
    fail_lamp_o [*3] |-> !fail_contact_closed_o)
    else $error("fail contact closed during failure");
  a_stop_no_display: assert property (
    fault_i[0] [*8] |-> !fail_display_main_o && !fail_display_disp_o)
    else $error("fail display with stopped clock");
  a_single_display: assert property (
    !(fail_display_main_o && fail_display_disp_o))
    else $error("both fail displays on");
  a_both_fail_dark: assert property (
    (fault_i[1] && fault_i[2]) [*8] |-> !fail_display_main_o && !fail_display_disp_o)
    else $error("fail display with both processors down");
  a_cause_lights_lamp: assert property (
    (alarm_cause_o != 9'h000) [*3] |-> alarm_lamp_o)
    else $error("alarm cause without lamp");
  a_tag_needs_lamp: assert property (
    $rose(tag_invert_o) |-> alarm_lamp_o || $past(alarm_lamp_o))
    else $error("tag highlight without lamp");
  a_output_per_period: assert property (
    $changed(manipulated_output_o) |=> $stable(manipulated_output_o) [*8])
    else $error("output changed within a period");
  a_input_mode_release: assert property (
    backlight_off_o |-> !contact6_oe_o)
    else $error("contact six driven in input mode");
endmodule : pai_monitor

bind pai_top pai_monitor u_mon (.mclk_i, .reset_i, .power_ok_i, .fault_i,
  .contact_closed_o, .contact6_oe_o, .backlight_off_o, .manipulated_output_o,
  .alarm_lamp_o, .alarm_cause_o, .tag_invert_o, .fail_lamp_o,
  .fail_contact_closed_o, .fail_display_main_o, .fail_display_disp_o);

// ==== dv/process_alarm_indicator_logic_tb.sv ====
// Self-checking bench of the process alarm indicator
`timescale 1ns/1ps
`include "pai_cfg.svh"
module process_alarm_indicator_logic_tb;
  // Short period keeps outage counts of 25 ticks affordable
  localparam int PER = 50;
  logic mclk_i = 0;
  logic reset_i = 1;
  logic psel_i = 0, penable_i = 0, pwrite_i = 0, mains = 1, sysa = 0, sw = 0, rerr;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rdv;
  logic [15:0] lvl0 = 16'h01f4, lvl1 = 16'h01f4, process_value0_i, process_value1_i;
  logic [15:0] manipulated_output_o;
  logic [6:0] flt = 7'h00, fault_i;
  logic [8:0] alarm_cause_o;
  logic [5:0] contact_closed_o;
  logic [1:0] pv_bar_alert_o;
  logic pready_o, pslverr_o, power_ok_i, sys_alarm_i, contact_input_point_i, contact6_oe_o;
  logic backlight_off_o, alarm_lamp_o, tag_invert_o, fail_lamp_o, fail_contact_closed_o;
  logic fail_display_main_o, fail_display_disp_o, irq_o;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;

  pai_field u_field (.lvl0_i(lvl0), .lvl1_i(lvl1), .mains_i(mains), .flt_i(flt),
    .sys_i(sysa), .switch_i(sw), .contact6_oe_i(contact6_oe_o),
    .process_value0_o(process_value0_i), .process_value1_o(process_value1_i),
    .power_ok_o(power_ok_i), .fault_o(fault_i), .sys_alarm_o(sys_alarm_i),
    .contact_input_point_o(contact_input_point_i));

  pai_top #(.PERIOD_CYC(PER)) DUT (.mclk_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .process_value0_i,
    .process_value1_i, .power_ok_i, .fault_i, .sys_alarm_i, .contact_input_point_i,
    .contact_closed_o, .contact6_oe_o, .backlight_off_o, .manipulated_output_o,
    .alarm_lamp_o, .alarm_cause_o, .pv_bar_alert_o, .tag_invert_o, .fail_lamp_o,
    .fail_contact_closed_o, .fail_display_main_o, .fail_display_disp_o, .irq_o);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rdv = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask : apb

  task automatic tk(input int n);
    repeat (n * PER) @(posedge mclk_i);
  endtask : tk

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    apb(0, `PAI_OFS_CH0, 0);
    chk("hi sp", 32'h0000_03e8, rdv);
    apb(0, `PAI_OFS_CH0 + 12'h008, 0);
    chk("hh sp", 32'h0000_0427, rdv);
    apb(0, `PAI_OFS_CH1 + 12'h00c, 0);
    chk("ll sp", 32'hffff_ffc1, rdv);
    apb(0, `PAI_OFS_CH1 + 12'h010, 0);
    chk("hyst", 32'h0000_000a, rdv);
    apb(1, 12'h0ffc, 32'h0000_1234);
    chk("unmapped", 1, rerr);
  endtask : t_regs

  task automatic t_alarm();
    logic [15:0] v0[6] = '{16'h03e8, 16'h042e, 16'h03e3, 16'h03dd, 16'h01f4, 16'h01f4};
    logic [15:0] v1[6] = '{16'h01f4, 16'h01f4, 16'h01f4, 16'h01f4, 16'hffba, 16'h01f4};
    logic [8:0] ca[6] = '{9'h001, 9'h005, 9'h001, 9'h000, 9'h0a0, 9'h000};
    logic [5:0] cc[6] = '{6'h01, 6'h03, 6'h01, 6'h04, 6'h04, 6'h04};
    apb(1, `PAI_OFS_CONTACT, 32'h0000_0101);
    apb(1, `PAI_OFS_CONTACT + 12'h004, 32'h0000_0005);
    apb(1, `PAI_OFS_CONTACT + 12'h008, 32'h0000_0301);
    apb(1, `PAI_OFS_IRQ_MASK, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      lvl0 <= v0[i];
      lvl1 <= v1[i];
      tk(3);
      chk("causes", ca[i], alarm_cause_o);
      chk("lamp", ca[i] != 9'h000, alarm_lamp_o);
      chk("contacts", cc[i], contact_closed_o);
    end
    chk("irq", 1, irq_o);
    apb(0, `PAI_OFS_IRQ_STAT, 0);
    chk("irq stat", 32'h0000_00a5, rdv);
    repeat (2) @(posedge mclk_i);
    chk("irq clear", 0, irq_o);
  endtask : t_alarm

  task automatic t_clamp();
    logic [31:0] ct[5] = '{0, 0, 32'h0000_0040, 32'h0000_0040, 32'h0000_0040};
    logic [15:0] cu[5] = '{0, 0, 0, 16'h012c, 16'h012c};
    logic [15:0] pv[5] = '{16'h04b0, 16'hff9c, 16'h00fa, 16'h00fa, 16'h0168};
    logic [15:0] ex[5] = '{16'h0427, 16'hffc1, 16'h01f4, 16'h0000, 16'h0258};
    for (int i = 0; i < 5; i++) begin
      apb(1, `PAI_OFS_CTRL, ct[i]);
      apb(1, `PAI_OFS_CH0 + 12'h018, {16'h0000, cu[i]});
      lvl0 <= pv[i];
      tk(3);
      chk("output", ex[i], manipulated_output_o);
    end
    apb(1, `PAI_OFS_CTRL, 0);
  endtask : t_clamp

  task automatic t_filter();
    logic [15:0] ex[3] = '{16'h01f4, 16'h02ee, 16'h036b};
    logic [15:0] prev;
    lvl0 <= 16'h0000;
    tk(3);
    apb(1, `PAI_OFS_CH0 + 12'h014, 1);
    lvl0 <= 16'h03e8;
    for (int k = 0; k < 3; k++) begin
      prev = manipulated_output_o;
      while (manipulated_output_o === prev) @(posedge mclk_i);
      chk("lag", ex[k], manipulated_output_o);
    end
  endtask : t_filter

  task automatic t_power();
    int ot[3] = '{25, 10, 25};
    logic [31:0] md[3] = '{1, 1, 0};
    logic [15:0] ex[3] = '{16'h0000, 16'h01f4, 16'h01f4};
    for (int i = 0; i < 3; i++) begin
      apb(1, `PAI_OFS_CH0 + 12'h014, 0);
      apb(1, `PAI_OFS_CTRL, md[i]);
      lvl0 <= 16'h03e8;
      tk(3);
      mains <= 1'b0;
      tk(1);
      chk("lost contacts", 0, contact_closed_o);
      chk("lost fail contact", 0, fail_contact_closed_o);
      apb(1, `PAI_OFS_CH0 + 12'h014, 1);
      lvl0 <= 16'h0000;
      tk(ot[i] - 1);
      mains <= 1'b1;
      while (manipulated_output_o === 16'h03e8) @(posedge mclk_i);
      chk("restart", ex[i], manipulated_output_o);
      apb(0, `PAI_OFS_STATUS, 0);
      chk("hot flag", ex[i] != 16'h0000, rdv[10]);
      apb(0, `PAI_OFS_CH0 + 12'h014, 0);
      chk("kept tau", 1, rdv);
    end
  endtask : t_power

  task automatic t_disp();
    logic t0;
    logic chg;
    apb(1, `PAI_OFS_CH0 + 12'h014, 0);
    apb(1, `PAI_OFS_CTRL, 32'h0000_000e);
    lvl0 <= 16'h01f4;
    sysa <= 1'b1;
    sw <= 1'b1;
    tk(3);
    chk("sys cause", 9'h100, alarm_cause_o);
    chk("bar idle", 0, pv_bar_alert_o);
    chk("backlight", 1, backlight_off_o);
    chk("c6 oe", 0, contact6_oe_o);
    t0 = tag_invert_o;
    chg = 1'b0;
    repeat (60) begin
      @(posedge mclk_i);
      chg = chg | (tag_invert_o !== t0);
    end
    chk("tag", 1, chg);
    sysa <= 1'b0;
    sw <= 1'b0;
    lvl0 <= 16'h03e8;
    tk(3);
    chk("bar hi", 2'b01, pv_bar_alert_o);
    apb(1, `PAI_OFS_CTRL, 32'h0000_0024);
    tk(1);
    chk("bar hh idle", 0, pv_bar_alert_o);
    lvl0 <= 16'h042e;
    tk(3);
    chk("bar hh", 2'b01, pv_bar_alert_o);
  endtask : t_disp

  task automatic t_fail();
    logic [6:0] f;
    for (int i = 0; i < 8; i++) begin
      f = (i < 7) ? 7'(1 << i) : 7'h06;
      reset_i <= 1'b1;
      flt <= 7'h00;
      tk(1);
      reset_i <= 1'b0;
      flt <= f;
      tk(3);
      chk("fail lamp", 1, fail_lamp_o);
      chk("fail contact", 0, fail_contact_closed_o);
      chk("main disp", !f[0] && !f[1], fail_display_main_o);
      chk("spare disp", f[1] && !f[2] && !f[0], fail_display_disp_o);
    end
  endtask : t_fail

  initial begin
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    t_regs();
    t_alarm();
    t_clamp();
    t_filter();
    t_power();
    t_disp();
    t_fail();
    results();
  end
endmodule : process_alarm_indicator_logic_tb
